// file: pkg/dssr_pkg.sv
// package for the dual sample serial readout: frame positions and result types
package dssr_pkg;
  localparam int RES_W = 12;
  localparam logic [5:0] FRAME_LEN = 6'd32;
  localparam logic [5:0] EDGE_HOLD = 6'd4;
  localparam logic [5:0] A_FIRST = 6'd5;
  localparam logic [5:0] A_LAST = 6'd16;
  localparam logic [5:0] GAP_FIRST = 6'd17;
  localparam logic [5:0] B_FIRST = 6'd21;
  localparam logic [5:0] B_LAST = 6'd32;
  localparam logic [5:0] CNT_RST = 6'h00;
  localparam logic [3:0] MSB_POS = 4'hb;
  localparam logic [11:0] POS_FULL = 12'h7ff;
  localparam logic [11:0] NEG_FULL = 12'h800;
  localparam logic [11:0] SIGN_FLIP = 12'h800;
  localparam logic [11:0] RES_RST = 12'h000;

  typedef struct packed {
    logic [11:0] chan_a;
    logic [11:0] chan_b;
  } dssr_pair_t;
endpackage : dssr_pkg

// file: core/dssr_core.sv
// serial result framing with parallel result buffer for the dual sample converter
`timescale 1ns/1ps
module dssr_core #(
  parameter int IN_W = 14
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic signed [IN_W-1:0] first_channel_difference,
  input wire logic signed [IN_W-1:0] second_channel_difference,
  output logic dout,
  output logic dout_oe,
  output dssr_pkg::dssr_pair_t result,
  output logic result_valid,
  input wire logic result_ready,
  output logic result_room
);

  logic sclk_q_reg;
  logic cs_q_reg;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic edge_w;
  logic [11:0] held_a_reg;
  logic [11:0] held_b_reg;
  logic [11:0] approx_a_reg;
  logic [11:0] approx_b_reg;
  logic [11:0] approx_a_next;
  logic [11:0] approx_b_next;
  logic [3:0] pos_w;
  logic dout_reg;
  logic dout_next;
  logic dout_oe_reg;
  logic push_w;
  logic pop_w;
  dssr_pkg::dssr_pair_t out_data_reg;
  dssr_pkg::dssr_pair_t skid_data_reg;
  dssr_pkg::dssr_pair_t in_data_w;
  logic out_valid_reg;
  logic skid_valid_reg;
  logic room_reg;

  // saturate the difference input to the 12-bit code range
  function automatic logic [11:0] clamp(input logic signed [IN_W-1:0] x);
    logic signed [IN_W-1:0] hi;
    logic signed [IN_W-1:0] lo;
    hi = IN_W'(signed'(2047));
    lo = IN_W'(signed'(-2048));
    if (x >= hi)
    begin
      clamp = dssr_pkg::POS_FULL;
    end
    else if (x <= lo)
    begin
      clamp = dssr_pkg::NEG_FULL;
    end
    else
    begin
      clamp = x[11:0];
    end
  endfunction : clamp

  // one successive approximation step on offset binary
  function automatic logic [11:0] sar_step(input logic [11:0] held, input logic [11:0] approx,
                                           input logic [3:0] pos);
    logic [11:0] trial;
    trial = approx | (12'h001 << pos);
    sar_step = ((held ^ dssr_pkg::SIGN_FLIP) >= trial) ? trial : approx;
  endfunction : sar_step

  // select low with clock low counts as the first falling edge
  assign edge_w = !cs_n && ((sclk_q_reg && !sclk) || (cs_q_reg && !sclk));

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sclk_q_reg <= 1'b0;
      cs_q_reg <= 1'b1;
    end
    else
    begin
      sclk_q_reg <= sclk;
      cs_q_reg <= cs_n;
    end
  end

  always_comb
  begin
    cnt_next = cnt_reg;
    if (edge_w)
    begin
      cnt_next = (cnt_reg == dssr_pkg::FRAME_LEN) ? 6'd1 : cnt_reg + 6'd1;
    end
  end

  // edge counter, cleared whenever select is high
  always_ff @(posedge clk)
  begin
    if (sys_rst || cs_n)
    begin
      cnt_reg <= dssr_pkg::CNT_RST;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  // common hold of both channels
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      held_a_reg <= dssr_pkg::RES_RST;
      held_b_reg <= dssr_pkg::RES_RST;
    end
    else if (edge_w && cnt_next == dssr_pkg::EDGE_HOLD)
    begin
      held_a_reg <= clamp(first_channel_difference);
      held_b_reg <= clamp(second_channel_difference);
    end
  end

  always_comb
  begin
    pos_w = 4'h0;
    approx_a_next = approx_a_reg;
    approx_b_next = approx_b_reg;
    dout_next = dout_reg;
    if (cnt_next >= dssr_pkg::A_FIRST && cnt_next <= dssr_pkg::A_LAST)
    begin
      pos_w = 4'(dssr_pkg::A_LAST - cnt_next);
      approx_a_next = sar_step(held_a_reg, approx_a_reg, pos_w);
      approx_b_next = sar_step(held_b_reg, approx_b_reg, pos_w);
      dout_next = approx_a_next[pos_w] ^ (pos_w == dssr_pkg::MSB_POS);
    end
    else if (cnt_next >= dssr_pkg::B_FIRST && cnt_next <= dssr_pkg::B_LAST)
    begin
      pos_w = 4'(dssr_pkg::B_LAST - cnt_next);
      dout_next = approx_b_reg[pos_w] ^ (pos_w == dssr_pkg::MSB_POS);
    end
    else
    begin
      dout_next = 1'b0;
    end
  end

  // conversion registers and serial bit, stepped on each falling edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      approx_a_reg <= dssr_pkg::RES_RST;
      approx_b_reg <= dssr_pkg::RES_RST;
      dout_reg <= 1'b0;
    end
    else if (edge_w)
    begin
      if (cnt_next == dssr_pkg::EDGE_HOLD)
      begin
        approx_a_reg <= dssr_pkg::RES_RST;
        approx_b_reg <= dssr_pkg::RES_RST;
      end
      else
      begin
        approx_a_reg <= approx_a_next;
        approx_b_reg <= approx_b_next;
      end
      dout_reg <= dout_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dout_oe_reg <= 1'b0;
    end
    else
    begin
      dout_oe_reg <= !cs_n;
    end
  end

  // two-entry buffer: output register plus skid register
  assign in_data_w = '{chan_a: approx_a_reg ^ dssr_pkg::SIGN_FLIP,
                       chan_b: approx_b_reg ^ dssr_pkg::SIGN_FLIP};
  assign push_w = edge_w && cnt_next == dssr_pkg::GAP_FIRST && !skid_valid_reg;
  assign pop_w = out_valid_reg && result_ready;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      out_valid_reg <= 1'b0;
      skid_valid_reg <= 1'b0;
      room_reg <= 1'b1;
      out_data_reg <= '0;
      skid_data_reg <= '0;
    end
    else if (!out_valid_reg || pop_w)
    begin
      if (skid_valid_reg)
      begin
        out_data_reg <= skid_data_reg;
        out_valid_reg <= 1'b1;
        skid_valid_reg <= push_w;
        room_reg <= !push_w;
        if (push_w)
        begin
          skid_data_reg <= in_data_w;
        end
      end
      else
      begin
        out_valid_reg <= push_w;
        if (push_w)
        begin
          out_data_reg <= in_data_w;
        end
      end
    end
    else if (push_w)
    begin
      skid_valid_reg <= 1'b1;
      room_reg <= 1'b0;
      skid_data_reg <= in_data_w;
    end
  end

  assign dout = dout_reg;
  assign dout_oe = dout_oe_reg;
  assign result = out_data_reg;
  assign result_valid = out_valid_reg;
  assign result_room = room_reg;

  sequence s_hold_edge;
    edge_w && cnt_reg == 6'd3;
  endsequence

  sequence s_wrap_edge;
    edge_w && cnt_reg == 6'd32;
  endsequence

  a_count_range: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_reg <= 6'd32) else $error("edge count beyond frame length");

  a_frame_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    s_wrap_edge |=> cnt_reg == 6'd1 && dout_oe_reg) else $error("no restart after 32 edges");

  a_select_abort: assert property (@(posedge clk) disable iff (sys_rst)
    cs_n |=> cnt_reg == 6'd0 && !dout_oe_reg) else $error("frame not aborted on select high");

  a_output_enable: assert property (@(posedge clk) disable iff (sys_rst)
    !cs_n ##1 !cs_n |-> dout_oe_reg) else $error("output not driven while selected");

  a_lead_zeros: assert property (@(posedge clk) disable iff (sys_rst)
    (cnt_reg >= 6'd1 && cnt_reg <= 6'd4) |-> !dout_reg) else $error("leading bit not zero");

  a_gap_zeros: assert property (@(posedge clk) disable iff (sys_rst)
    (cnt_reg >= 6'd17 && cnt_reg <= 6'd20) |-> !dout_reg) else $error("gap bit not zero");

  a_track_window: assert property (@(posedge clk) disable iff (sys_rst)
    (cnt_reg >= 6'd1 && cnt_reg <= 6'd3) |-> $stable(held_a_reg)) else $error("held too early");

  a_common_hold: assert property (@(posedge clk) disable iff (sys_rst)
    s_hold_edge |=> held_a_reg == clamp($past(first_channel_difference)) &&
    held_b_reg == clamp($past(second_channel_difference))) else $error("hold mismatch");

  a_clamp_high: assert property (@(posedge clk) disable iff (sys_rst)
    s_hold_edge and (first_channel_difference >= 2047) |=> held_a_reg == 12'h7ff)
    else $error("positive full scale not 7ff");

  a_clamp_low: assert property (@(posedge clk) disable iff (sys_rst)
    s_hold_edge and (first_channel_difference <= -2048) |=> held_a_reg == 12'h800)
    else $error("negative full scale not 800");

  a_sign_first: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_reg == 6'd5 |-> dout_reg == held_a_reg[11]) else $error("first bit not sign");

  a_a_result: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_reg >= 6'd16 |-> (approx_a_reg ^ 12'h800) == held_a_reg) else $error("a result wrong");

endmodule : dssr_core

// file: sim/dssr_host.sv
// serial host model driving frame select and serial clock
`timescale 1ns/1ps
module dssr_host (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  output logic cs_n,
  output logic sclk
);
  int ph = 0;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
  end
  // clock stands high between frames, three clk high and three low inside
  always @(posedge clk)
  begin
    #1;
    if (sys_rst || !run)
    begin
      cs_n = 1'b1;
      sclk = 1'b1;
      ph = 0;
    end
    else
    begin
      cs_n = 1'b0;
      ph = (ph == 5) ? 0 : ph + 1;
      sclk = (ph >= 3);
    end
  end
endmodule : dssr_host

// file: sim/tb_dssr_core.sv
// self-checking bench for the dual sample serial readout
`timescale 1ns/1ps
module tb_dssr_core;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b0;
  logic hold = 1'b0;
  logic result_ready = 1'b0;
  logic cs_n, sclk, dout, dout_oe, result_valid, result_room;
  logic signed [13:0] in_a = '0;
  logic signed [13:0] in_b = '0;
  logic signed [13:0] ta[4] = '{14'sd2047, 14'sd3000, -14'sd2048, -14'sd8000};
  logic signed [13:0] tb[4] = '{-14'sd2048, -14'sd5000, 14'sd2047, 14'sd8191};
  dssr_pkg::dssr_pair_t result;
  logic [31:0] sq[$];
  logic [23:0] rq[$];
  logic [31:0] word = '0;
  int cnt = 0, failures = 0, checked = 0, cycles = 0;
  integer seed = 32'h3e39;
  event half_ev, done_ev;

  always #5 clk = ~clk;

  dssr_host u_dssr_host (.clk(clk), .sys_rst(sys_rst), .run(run), .cs_n(cs_n), .sclk(sclk));
  dssr_core #(.IN_W(14)) u_dssr_core (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .sclk(sclk), .first_channel_difference(in_a), .second_channel_difference(in_b),
    .dout(dout), .dout_oe(dout_oe), .result(result), .result_valid(result_valid),
    .result_ready(result_ready), .result_room(result_room));

  function automatic logic [11:0] clip(logic signed [13:0] x);
    return (x > 14'sd2047) ? 12'h7ff : (x < -14'sd2048) ? 12'h800 : x[11:0];
  endfunction : clip

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // new inputs, noted for the serial word and, if kept, the parallel pair
  task automatic set_in(int i, bit keep);
    in_a = (i < 4) ? ta[i] : 14'($random(seed));
    in_b = (i < 4) ? tb[i] : 14'($random(seed));
    sq.push_back({4'h0, clip(in_a), 4'h0, clip(in_b)});
    if (keep)
      rq.push_back({clip(in_a), clip(in_b)});
  endtask : set_in

  task automatic open_frame();
    run = 1'b1;
    repeat (3) @(posedge clk);
    #2 check(dout_oe, 1'b1);
  endtask : open_frame

  task automatic close_frame();
    run = 1'b0;
    repeat (3) @(posedge clk);
    #2 check(dout_oe, 1'b0);
  endtask : close_frame

  // host samples each bit on the rising edge after it changed
  always @(posedge sclk)
    if (!cs_n)
    begin
      word = {word[30:0], dout};
      cnt++;
      if (cnt == 16)
        ->half_ev;
      if (cnt == 32)
      begin
        check(word, sq.pop_front());
        cnt = 0;
        ->done_ev;
      end
    end

  always @(posedge cs_n)
    cnt = 0;

  always @(posedge clk)
    result_ready <= #1 ~hold & 1'($random(seed));

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      failures++;
      complete_run();
    end
  end

  // handshake seen mid-cycle, taken at the next rising edge
  always @(negedge clk)
    if (result_valid && result_ready)
      check(result, rq.size() ? rq.pop_front() : 24'hx);

  initial
  begin
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    set_in(0, 1'b1);
    open_frame();
    for (int i = 1; i < 12; i++)
    begin
      @half_ev;
      if (i == 5)
        hold = 1'b1;
      // release after pair 6 is dropped, long before pair 7 is pushed
      if (i == 7)
      begin
        @done_ev;
        check(result_room, 1'b0);
        hold = 1'b0;
      end
      set_in(i, i != 6);
    end
    repeat (2) @done_ev;
    close_frame();
    $display("continuous conversion test done");
    set_in(12, 1'b0);
    void'(sq.pop_back());
    open_frame();
    repeat (10) @(posedge sclk);
    close_frame();
    repeat (50) @(posedge clk);
    #2 check(result_valid, 1'b0);
    $display("abort test done");
    set_in(13, 1'b1);
    open_frame();
    @done_ev;
    close_frame();
    repeat (50) @(posedge clk);
    $display("restart test done");
    check(rq.size() + sq.size(), 0);
    complete_run();
  end
endmodule : tb_dssr_core
